// ===== core/pcu_cap_slot.sv
// One capture slot: holds a position, new-data and overrun flags
`timescale 1ns/1ns
module pcu_cap_slot
  import pcu_pkg::*;
#(
  parameter int W = POS_W
) (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_event, // Capture event pulse
  input wire logic i_keep, // Do not overwrite until read
  input wire logic [W-1:0] i_pos, // Position to capture
  input wire logic i_read, // Software read of the held value
  output logic [W-1:0] o_pos, // Held position
  output logic o_new, // Capture flag
  output logic o_ovr // Overrun flag
);
  logic [W-1:0] next_pos;
  logic next_new;
  logic next_ovr;
  always_comb begin
    next_pos = o_pos;
    next_new = o_new;
    next_ovr = o_ovr;
    if (i_read) begin
      next_new = 1'b0;
      next_ovr = 1'b0;
    end
    // Event beats a same-cycle read
    if (i_event) begin
      if (o_new && !i_read) begin
        next_ovr = 1'b1;
        if (!i_keep) begin
          next_pos = i_pos;
        end
      end else begin
        next_pos = i_pos;
      end
      next_new = 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pos <= '0;
      o_new <= 1'b0;
      o_ovr <= 1'b0;
    end else begin
      o_pos <= next_pos;
      o_new <= next_new;
      o_ovr <= next_ovr;
    end
  end
endmodule

// ===== core/pcu_sync.sv
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module pcu_sync #(
  parameter int W = 1
) (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic [W-1:0] i_d, // Async input
  output logic [W-1:0] o_q // Synchronised output
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  always_comb begin
    next_meta = i_d;
    next_q = meta;
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= next_meta;
      o_q <= next_q;
    end
  end
endmodule

// ===== core/pcu_top.sv
// Position capture unit: index, home and high-speed capture with register port
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
module pcu_top
  import pcu_pkg::*;
#(
  parameter int PHASE_W = 16
) (
  input wire logic i_sys_clk, // Clock, 100 MHz
  input wire logic i_rst_n, // Async reset, active low
  input wire logic [ADDR_W+1:0] i_addr, // Byte address
  input wire logic [REG_W-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [POS_W-1:0] o_rdata, // Read data, cycle after strobe
  input wire logic i_index, // Encoder index pin
  input wire logic i_home, // Home switch pin, high is active
  input wire logic i_hs_in, // High-speed capture pin
  input wire logic i_pos_step, // Position count enable
  input wire logic i_pos_dir, // Count direction, 1 down
  input wire logic [PHASE_W-1:0] i_phase, // Present phase angle
  input wire logic i_phase_mode0, // Phase mode 0 or incremental encoder
  output logic [POS_W-1:0] o_position, // Actual position counter
  output logic o_phase_load, // Pulse: restore phase angle
  output logic [PHASE_W-1:0] o_phase_value, // Phase angle to restore
  output logic o_irq // Interrupt, active high level
);
  pcu_bus_t bus;
  logic [2:0] pins_s;
  logic [2:0] pins_d;
  logic [2:0] next_pins_d;
  logic [REG_W-1:0] control;
  logic [REG_W-1:0] next_control;
  logic [POS_W-1:0] next_position;
  logic [POS_W-1:0] next_rdata;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic next_irq;
  logic phase_saved_ok;
  logic next_phase_saved_ok;
  logic phase_en_d;
  logic next_phase_en_d;
  logic next_phase_load;
  logic [PHASE_W-1:0] next_phase_value;
  logic idx_ev;
  logic home_ev;
  logic hs_ev;
  logic rd_idx;
  logic rd_home;
  logic rd_hs;
  logic [POS_W-1:0] idx_pos;
  logic [POS_W-1:0] home_pos;
  logic [POS_W-1:0] hs_pos;
  logic [2:0] cap_new;
  logic [2:0] cap_ovr;
  logic hs_keep;
  logic [REG_W-1:0] status_word;
  logic [IRQ_W-1:0] irq_events;

  // Address match on a word index, low byte bits zero
  function automatic logic hit(input logic [ADDR_W+1:0] a, input logic [ADDR_W-1:0] idx);
    hit = (a == {idx, LOW_ZERO});
  endfunction

  // Edge decode of one synchronised pin against its delayed copy
  function automatic logic rise_of(input logic cur, input logic prev);
    rise_of = cur && !prev;
  endfunction

  function automatic logic fall_of(input logic cur, input logic prev);
    fall_of = !cur && prev;
  endfunction

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  pcu_sync #(
    .W(3)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_hs_in, i_home, i_index}),
    .o_q(pins_s)
  );

  // Edge selection on synchronised pins
  always_comb begin
    next_pins_d = pins_s;
    idx_ev = (control[C_IDX_RISE] && rise_of(pins_s[E_IDX], pins_d[E_IDX])) ||
             (control[C_IDX_FALL] && fall_of(pins_s[E_IDX], pins_d[E_IDX]));
    home_ev = control[C_HOME_FALL] ? fall_of(pins_s[E_HOME], pins_d[E_HOME])
                                   : rise_of(pins_s[E_HOME], pins_d[E_HOME]);
    hs_ev = control[C_HS_EN] && rise_of(pins_s[E_HS], pins_d[E_HS]);
  end

  assign rd_idx = bus.rd && hit(bus.addr, IDX_INDEX_POS);
  assign rd_home = bus.rd && hit(bus.addr, IDX_HOME_POS);
  assign rd_hs = bus.rd && hit(bus.addr, IDX_HS_POS);
  // Either don't-overwrite or latch holds the first capture
  assign hs_keep = control[C_HS_KEEP] || control[C_HS_LATCH];

  pcu_cap_slot u_idx (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_event(idx_ev),
    .i_keep(control[C_IDX_KEEP]),
    .i_pos(o_position),
    .i_read(rd_idx),
    .o_pos(idx_pos),
    .o_new(cap_new[E_IDX]),
    .o_ovr(cap_ovr[E_IDX])
  );

  pcu_cap_slot u_home (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_event(home_ev),
    .i_keep(control[C_HOME_KEEP]),
    .i_pos(o_position),
    .i_read(rd_home),
    .o_pos(home_pos),
    .o_new(cap_new[E_HOME]),
    .o_ovr(cap_ovr[E_HOME])
  );

  pcu_cap_slot u_hs (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_event(hs_ev),
    .i_keep(hs_keep),
    .i_pos(o_position),
    .i_read(rd_hs),
    .o_pos(hs_pos),
    .o_new(cap_new[E_HS]),
    .o_ovr(cap_ovr[E_HS])
  );

  always_comb begin
    status_word = '0;
    status_word[S_IDX_NEW] = cap_new[E_IDX];
    status_word[S_IDX_OVR] = cap_ovr[E_IDX];
    status_word[S_HOME_NEW] = cap_new[E_HOME];
    status_word[S_HOME_OVR] = cap_ovr[E_HOME];
    status_word[S_HS_NEW] = cap_new[E_HS];
    status_word[S_HS_OVR] = cap_ovr[E_HS];
  end

  // Control register, reserved bits read back as zero
  always_comb begin
    next_control = control;
    if (bus.wr && hit(bus.addr, IDX_CONTROL)) begin
      next_control = bus.wdata & CONTROL_MASK;
    end
  end

  // Position counter: index clear or a step overrides a load in the same cycle
  always_comb begin
    next_position = o_position;
    if (bus.wr && hit(bus.addr, IDX_POSITION)) begin
      next_position = {{(POS_W-REG_W){1'b0}}, bus.wdata};
    end
    if (idx_ev && control[C_IDX_CLR_POS]) begin
      next_position = '0;
    end else if (i_pos_step) begin
      next_position = i_pos_dir ? o_position - 1'b1 : o_position + 1'b1;
    end
  end

  // Phase save and restore, armed one cycle after the enable bit is set
  always_comb begin
    next_phase_en_d = control[C_PHASE_RST];
    next_phase_saved_ok = phase_saved_ok;
    next_phase_value = o_phase_value;
    next_phase_load = 1'b0;
    if (!control[C_PHASE_RST] || !phase_en_d) begin
      next_phase_saved_ok = 1'b0;
    end
    if (control[C_PHASE_RST] && phase_en_d && idx_ev) begin
      if (!phase_saved_ok) begin
        next_phase_value = i_phase;
        next_phase_saved_ok = 1'b1;
      end else begin
        next_phase_load = i_phase_mode0;
      end
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  always_comb begin
    irq_events = '0;
    irq_events[E_IDX] = idx_ev;
    irq_events[E_HOME] = home_ev;
    irq_events[E_HS] = hs_ev;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (bus.wr && hit(bus.addr, IDX_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~bus.wdata[IRQ_W-1:0];
    end
    if (bus.wr && hit(bus.addr, IDX_IRQ_MASK)) begin
      next_irq_mask = bus.wdata[IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // Read mux, data valid the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        {IDX_INDEX_POS, LOW_ZERO}: next_rdata = idx_pos;
        {IDX_HOME_POS, LOW_ZERO}: next_rdata = home_pos;
        {IDX_HS_POS, LOW_ZERO}: next_rdata = hs_pos;
        {IDX_CONTROL, LOW_ZERO}: next_rdata = {{(POS_W-REG_W){1'b0}}, control};
        {IDX_STATUS, LOW_ZERO}: next_rdata = {{(POS_W-REG_W){1'b0}}, status_word};
        {IDX_IRQ_STATUS, LOW_ZERO}: next_rdata = {{(POS_W-IRQ_W){1'b0}}, irq_status};
        {IDX_IRQ_MASK, LOW_ZERO}: next_rdata = {{(POS_W-IRQ_W){1'b0}}, irq_mask};
        {IDX_POSITION, LOW_ZERO}: next_rdata = o_position;
        {IDX_PHASE_SAVED, LOW_ZERO}: next_rdata = {{(POS_W-PHASE_W){1'b0}}, o_phase_value};
        default: next_rdata = '0;
      endcase
    end
  end

  // Delayed pin copies for edge detection
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_d <= '0;
    end else begin
      pins_d <= next_pins_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control <= CONTROL_RESET;
    end else begin
      control <= next_control;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_position <= '0;
    end else begin
      o_position <= next_position;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_saved_ok <= 1'b0;
      phase_en_d <= 1'b0;
      o_phase_load <= 1'b0;
      o_phase_value <= '0;
    end else begin
      phase_saved_ok <= next_phase_saved_ok;
      phase_en_d <= next_phase_en_d;
      o_phase_load <= next_phase_load;
      o_phase_value <= next_phase_value;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= '0;
      irq_mask <= '0;
      o_irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      o_irq <= next_irq;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end
endmodule

// ===== inc/pcu_pkg.sv
// Package for the position capture unit: register map, fields, types
package pcu_pkg;
  localparam int POS_W = 32;
  localparam int REG_W = 16;
  localparam int ADDR_W = 10;
  // Register offsets (not all multiples of four: index kept, byte addr = 4 x index)
  localparam logic [ADDR_W-1:0] IDX_INDEX_POS = 10'h068;
  localparam logic [ADDR_W-1:0] IDX_CONTROL = 10'h06C;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 10'h06D;
  localparam logic [ADDR_W-1:0] IDX_HOME_POS = 10'h10A;
  localparam logic [ADDR_W-1:0] IDX_HS_POS = 10'h111;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 10'h200;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 10'h201;
  localparam logic [ADDR_W-1:0] IDX_POSITION = 10'h202;
  localparam logic [ADDR_W-1:0] IDX_PHASE_SAVED = 10'h203;
  localparam logic [ADDR_W+1:0] ADDR_LOW_ZERO = 12'h000;
  localparam logic [1:0] LOW_ZERO = 2'h0;
  // Control bits
  localparam int C_IDX_RISE = 0;
  localparam int C_IDX_FALL = 1;
  localparam int C_IDX_KEEP = 2;
  localparam int C_HOME_FALL = 5;
  localparam int C_HOME_KEEP = 6;
  localparam int C_HS_EN = 8;
  localparam int C_HS_KEEP = 9;
  localparam int C_HS_LATCH = 10;
  localparam int C_IDX_CLR_POS = 12;
  localparam int C_PHASE_RST = 13;
  localparam logic [REG_W-1:0] CONTROL_MASK = 16'h3767;
  localparam logic [REG_W-1:0] CONTROL_RESET = 16'h0000;
  // Status bits
  localparam int S_IDX_NEW = 0;
  localparam int S_IDX_OVR = 3;
  localparam int S_HOME_NEW = 4;
  localparam int S_HOME_OVR = 7;
  localparam int S_HS_NEW = 8;
  localparam int S_HS_OVR = 11;
  // Interrupt events
  localparam int IRQ_W = 3;
  localparam int E_IDX = 0;
  localparam int E_HOME = 1;
  localparam int E_HS = 2;
  typedef struct packed {
    logic [ADDR_W+1:0] addr;
    logic [REG_W-1:0] wdata;
    logic wr;
    logic rd;
  } pcu_bus_t;
  typedef struct packed {
    logic hit;
    logic ovr;
  } pcu_cap_ev_t;
endpackage

// ===== test/pcu_checker_assertions.sv
// Port-level assertions for the position capture unit
`timescale 1ns/1ns
module pcu_checker
  import pcu_pkg::*;
#(
  parameter int PHASE_W = 16
) (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic [ADDR_W+1:0] i_addr, // Address
  input wire logic [REG_W-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write
  input wire logic i_rd, // Read
  input wire logic [POS_W-1:0] o_rdata, // Read data
  input wire logic i_index, // Index pin
  input wire logic i_home, // Home pin
  input wire logic i_hs_in, // Fast pin
  input wire logic i_pos_step, // Step
  input wire logic i_pos_dir, // Direction
  input wire logic [PHASE_W-1:0] i_phase, // Phase
  input wire logic i_phase_mode0, // Phase mode
  input wire logic [POS_W-1:0] o_position, // Position
  input wire logic o_phase_load, // Phase load
  input wire logic [PHASE_W-1:0] o_phase_value, // Saved phase
  input wire logic o_irq // Interrupt
);
  localparam logic [11:0] A_CTL = {IDX_CONTROL, LOW_ZERO};
  localparam logic [11:0] A_ST = {IDX_STATUS, LOW_ZERO};
  localparam logic [11:0] A_IDX = {IDX_INDEX_POS, LOW_ZERO};
  localparam logic [11:0] A_POS = {IDX_POSITION, LOW_ZERO};
  localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, LOW_ZERO};
  logic [REG_W-1:0] ctl;
  logic [REG_W-1:0] next_ctl;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Shadow of the control register
  always_comb begin
    next_ctl = ctl;
    if (i_wr && i_addr == A_CTL)
      next_ctl = i_wdata;
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
      ctl <= 16'h0000;
    else
      ctl <= next_ctl;
  a_ctl_readback: assert property (i_rd && i_addr == A_CTL |=>
    o_rdata == {16'h0000, ctl & 16'h3767}) else $error("control readback wrong");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not idle");
  a_idx_flags_clear: assert property (i_rd && i_addr == A_IDX ##2
    i_rd && i_addr == A_ST |=> o_rdata[3:0] == 4'h0) else $error("index flags kept");
  a_pos_count_up: assert property (i_pos_step && !i_pos_dir && !ctl[12]
    && !(i_wr && i_addr == A_POS) |=> o_position == $past(o_position) + 32'h1)
    else $error("position did not count");
  a_idx_pos_zero: assert property ($rose(i_index) && ctl[0] && ctl[12]
    && !i_pos_step |-> ##[3:5] o_position == 32'h0) else $error("position not cleared");
  a_load_single: assert property (o_phase_load |=> !o_phase_load)
    else $error("phase load longer than one cycle");
  a_load_cause: assert property (o_phase_load |-> ctl[13] && i_phase_mode0)
    else $error("phase load without cause");
  a_irq_masked: assert property (i_wr && i_addr == A_MSK && i_wdata[2:0] == 3'h0
    |-> ##1 !o_irq) else $error("masked interrupt still high");
endmodule

// ===== test/pcu_pin_model.sv
// Driver of the index, home and high-speed capture pins
`timescale 1ns/1ns
module pcu_pin_model (
  input wire logic i_sys_clk, // Clock
  output logic [2:0] o_pins // Index, home, high-speed
);
  initial o_pins = 3'h0;
  // Active four cycles, then idle long enough for the capture to land
  task automatic pulse(input int k);
    @(posedge i_sys_clk);
    o_pins[k] <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_pins[k] <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
  endtask
endmodule

// ===== test/pcu_top_tb_top.sv
// Self-checking bench for the position capture unit
`timescale 1ns/1ns
module pcu_top_tb_top
  import pcu_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [ADDR_W+1:0] i_addr = 12'h000;
  logic [REG_W-1:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_pos_step = 1'b0;
  logic i_pos_dir = 1'b0;
  logic [15:0] i_phase = 16'h1234;
  logic i_phase_mode0 = 1'b1;
  logic [2:0] pins;
  logic [POS_W-1:0] o_rdata;
  logic [POS_W-1:0] o_position;
  logic o_phase_load;
  logic o_irq;
  logic [15:0] o_phase_value;
  int failures = 0;
  int tests_run = 0;
  int loads = 0;
  // Rows: control, status after two pin pulses, held position, pin
  logic [15:0] rc [10] = '{16'h0005, 16'h0002, 16'h0000, 16'h0040, 16'h0020,
    16'h0000, 16'h0100, 16'h0300, 16'h0500, 16'h1001};
  logic [15:0] rs [10] = '{16'h0009, 16'h0009, 16'h0000, 16'h0090, 16'h0090,
    16'h0000, 16'h0900, 16'h0900, 16'h0900, 16'h0009};
  logic [15:0] re [10] = '{16'h0001, 16'h0012, 16'h0012, 16'h0031, 16'h0042,
    16'h0000, 16'h0062, 16'h0071, 16'h0081, 16'h0092};
  int rp [10] = '{0, 0, 0, 1, 1, 2, 2, 2, 2, 0};
  logic [9:0] preg [3] = '{IDX_INDEX_POS, IDX_HOME_POS, IDX_HS_POS};

  always #5 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk) begin
    if (o_phase_load === 1'b1)
      loads++;
  end

  pcu_pin_model pin_u (.i_sys_clk(i_sys_clk), .o_pins(pins));
  pcu_top dut_u (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_index(pins[0]),
    .i_home(pins[1]),
    .i_hs_in(pins[2]),
    .i_pos_step(i_pos_step),
    .i_pos_dir(i_pos_dir),
    .i_phase(i_phase),
    .i_phase_mode0(i_phase_mode0),
    .o_position(o_position),
    .o_phase_load(o_phase_load),
    .o_phase_value(o_phase_value),
    .o_irq(o_irq)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [15:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= {idx, LOW_ZERO};
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= {idx, LOW_ZERO};
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("Checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(IDX_CONTROL, 32'h0);
    wr(IDX_CONTROL, 16'hFFFF);
    rd(IDX_CONTROL, 32'h3767);
    rd(10'h3FF, 32'h0);
    wr(IDX_STATUS, 16'hFFFF);
    rd(IDX_STATUS, 32'h0);
    // Two pin pulses per row, each at its own position
    for (int r = 0; r < 10; r++) begin
      wr(IDX_CONTROL, rc[r]);
      wr(IDX_POSITION, 16'(r * 16 + 1));
      pin_u.pulse(rp[r]);
      wr(IDX_POSITION, 16'(r * 16 + 2));
      pin_u.pulse(rp[r]);
      rd(IDX_STATUS, {16'h0000, rs[r]});
      rd(preg[rp[r]], {16'h0000, re[r]});
      rd(IDX_STATUS, 32'h0);
    end
    chk(o_position, 32'h0);
    rd(IDX_IRQ_STATUS, 32'h7);
    wr(IDX_IRQ_MASK, 16'h0007);
    idle(2);
    chk(o_irq, 1'b1);
    wr(IDX_IRQ_MASK, 16'h0000);
    idle(2);
    chk(o_irq, 1'b0);
    wr(IDX_IRQ_MASK, 16'h0007);
    wr(IDX_IRQ_STATUS, 16'h0007);
    idle(2);
    chk(o_irq, 1'b0);
    rd(IDX_IRQ_STATUS, 32'h0);
    // Save at the first index event, restore later only in phase mode 0
    wr(IDX_CONTROL, 16'h2001);
    pin_u.pulse(0);
    i_phase <= 16'h5678;
    pin_u.pulse(0);
    i_phase_mode0 <= 1'b0;
    pin_u.pulse(0);
    chk(o_phase_value, 32'h1234);
    chk(loads, 32'h1);
    i_pos_step <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    i_pos_dir <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_pos_step <= 1'b0;
    idle(1);
    chk(o_position, 32'h2);
    report_and_stop();
  end
endmodule

bind pcu_top pcu_checker #(.PHASE_W(PHASE_W)) chk_u (
  .i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_index(i_index),
  .i_home(i_home),
  .i_hs_in(i_hs_in),
  .i_pos_step(i_pos_step),
  .i_pos_dir(i_pos_dir),
  .i_phase(i_phase),
  .i_phase_mode0(i_phase_mode0),
  .o_position(o_position),
  .o_phase_load(o_phase_load),
  .o_phase_value(o_phase_value),
  .o_irq(o_irq)
);
